//--- core/pfp_top.sv
`timescale 1ns/1ns
`default_nettype none
// How it works
// - state bit 3 low on load, high on erase or write start
// - bit 2 low at cycle start, high if clean
// - bit 1 low in brownout, forces bit 0
// - bit 0 low while busy or inhibited
// - busy read returns last byte, msb inverted
// - erase polling returns 7f until done
// - poll reference is last byte loaded
// - bytes captured on strobe rising edge
// - select high resets interface, bus released
// - ready pin low while busy, any select
// - read data driven from fourth strobe fall
// - program enable first in each session
// - enable is preamble, enable, confirm bytes
// - erase is preamble plus erase code
// - erase array, user row by fuse, unlock
// - load fills buffer without programming
// - offset from low five bits, wraps
// - buffer kept until write done or session end
// - target page from address bits 11:5
// - write programs when select rises
// - state byte read with two zero bytes
module pfp_top
#(
    parameter int ERASE_CYCLES = pfp_pkg::ERASE_CYCLES_DEF,
    parameter int WRITE_CYCLES = pfp_pkg::WRITE_CYCLES_DEF
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // programming pins
    input wire logic [pfp_pkg::BUS_W-1:0] i_byte_bus,
    output logic [pfp_pkg::BUS_W-1:0] o_byte_bus,
    output logic o_byte_bus_oe,
    input wire logic i_byte_strobe,
    input wire logic i_iface_select_n,
    input wire logic i_vpp_session,
    output logic o_ready_busy,
    // analog and fuse inputs
    input wire logic i_brownout,
    input wire logic i_user_row_fuse_n,
    // flash array side
    output logic o_flash_we,
    output logic [pfp_pkg::FADDR_W-1:0] o_flash_waddr,
    output logic [pfp_pkg::BUS_W-1:0] o_flash_wdata,
    output logic [pfp_pkg::FADDR_W-1:0] o_flash_raddr,
    input wire logic [pfp_pkg::BUS_W-1:0] i_flash_rdata,
    output logic o_flash_erase,
    output logic o_erase_user_row,
    output logic o_lock_clear
);
    import pfp_pkg::*;

    // ======================================================
    // helpers
    function automatic logic is_prog_cmd(input logic [BUS_W-1:0] c);
        is_prog_cmd = (c == CMD_ERASE) || (c == CMD_LOAD) ||
                      (c == CMD_WRITE);
    endfunction

    function automatic logic is_known_cmd(input logic [BUS_W-1:0] c);
        is_known_cmd = is_prog_cmd(c) || (c == CMD_ENABLE) ||
                       (c == CMD_STATUS) || (c == CMD_READ_CODE);
    endfunction

    function automatic logic [PAGE_W-1:0] page_of(
        input logic [BUS_W-1:0] hi,
        input logic [BUS_W-1:0] lo);
        page_of = {hi[3:0], lo[7:5]};
    endfunction

    // ======================================================
    // pin synchronisation and edges
    logic [SYNC_W-1:0] sync;
    logic [BUS_W-1:0] bus_s;
    logic strobe_s;
    logic sel_n_s;
    logic vpp_s;
    logic bo_s;
    logic strobe_prev;
    logic sel_n_prev;
    logic strobe_rise;
    logic strobe_fall;
    logic sel_rise;
    logic take;

    pfp_sync u_sync
    (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .i_async({i_brownout, i_vpp_session, i_iface_select_n,
                  i_byte_strobe, i_byte_bus}),
        .o_sync(sync)
    );

    // lanes out of the synchroniser
    assign bus_s = sync[SY_BUS_LSB +: BUS_W];
    assign strobe_s = sync[SY_STROBE];
    assign sel_n_s = sync[SY_SEL_N];
    assign vpp_s = sync[SY_VPP];
    assign bo_s = sync[SY_BROWNOUT];

    // previous levels for edge detection
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            strobe_prev <= 1'b0;
            sel_n_prev <= 1'b1;
        end
        else
        begin
            strobe_prev <= strobe_s;
            sel_n_prev <= sel_n_s;
        end
    end

    // edges; strobes only count inside a select-low frame
    assign strobe_rise = strobe_s && !strobe_prev;
    assign strobe_fall = !strobe_s && strobe_prev;
    assign sel_rise = sel_n_s && !sel_n_prev && vpp_s;
    assign take = strobe_rise && !sel_n_s && vpp_s;

    // ======================================================
    // command framing
    pfp_cmd_state_e state;
    pfp_prog_state_e pstate;
    logic [NSTB_W-1:0] nstrobe;
    logic [BUS_W-1:0] cmd;
    logic [BUS_W-1:0] addr_hi;
    logic [BUS_W-1:0] addr_lo;
    logic [OFS_W-1:0] offset;
    logic session;
    logic busy;
    logic code_ok;
    logic drive;

    assign busy = (pstate != P_IDLE);

    // gate commands on session and engine state
    assign code_ok = session ?
        (is_known_cmd(bus_s) && !(busy && is_prog_cmd(bus_s))) :
        (bus_s == CMD_ENABLE);

    // framing state machine, reset while select is high
    always_ff @(posedge i_clock)
    begin
        if (i_reset || !vpp_s || sel_n_s)
        begin
            state <= ST_PRE;
            nstrobe <= '0;
        end
        else if (strobe_rise)
        begin
            if (nstrobe != NSTB_MAX)
            begin
                nstrobe <= nstrobe + 3'h1;
            end
            unique case (state)
                ST_PRE:
                    state <= (bus_s == CMD_PREAMBLE) ? ST_CODE : ST_SKIP;
                ST_CODE:
                    state <= code_ok ? ST_ARG1 : ST_SKIP;
                ST_ARG1:
                    state <= (cmd == CMD_ENABLE || cmd == CMD_ERASE) ?
                             ST_SKIP : ST_ARG2;
                ST_ARG2:
                    state <= ST_DATA;
                ST_DATA:
                    state <= ST_DATA;
                ST_SKIP:
                    state <= ST_SKIP;
            endcase
        end
    end

    // command and address capture
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            cmd <= '0;
            addr_hi <= '0;
            addr_lo <= '0;
        end
        else if (take)
        begin
            if (state == ST_CODE)
            begin
                cmd <= bus_s;
            end
            if (state == ST_ARG1)
            begin
                addr_hi <= bus_s;
            end
            if (state == ST_ARG2)
            begin
                addr_lo <= bus_s;
            end
        end
    end

    // session opens on preamble, enable, confirm
    always_ff @(posedge i_clock)
    begin
        if (i_reset || !vpp_s)
        begin
            session <= 1'b0;
        end
        else if (take && state == ST_ARG1 && cmd == CMD_ENABLE &&
                 bus_s == CMD_CONFIRM)
        begin
            session <= 1'b1;
        end
    end

    // in-page offset: load at low address, step on strobe fall
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            offset <= '0;
        end
        else if (take && state == ST_ARG2)
        begin
            offset <= bus_s[OFS_W-1:0];
        end
        else if (strobe_fall && !sel_n_s && state == ST_DATA &&
                 nstrobe > READ_STROBE)
        begin
            offset <= offset + 5'h01;
        end
    end

    // ======================================================
    // page buffer
    logic buf_we;
    logic [PAGE_BYTES-1:0] loaded;
    logic [BUS_W-1:0] buf_rdata;
    logic [BUS_W-1:0] poll_ref;
    logic [WCNT_W-1:0] wcnt;
    logic [OFS_W-1:0] walk_ofs;
    logic cycle_start;
    logic cycle_done;
    logic erase_go;
    logic write_go;
    logic erase_mode;

    // data bytes of load and write go to the buffer only
    assign buf_we = take && state == ST_DATA &&
                    (cmd == CMD_LOAD || cmd == CMD_WRITE);
    assign walk_ofs = OFS_W'(wcnt - 6'h01);

    pfp_page_buf u_buf
    (
        .i_clock(i_clock),
        .i_we(buf_we),
        .i_waddr(offset),
        .i_wdata(bus_s),
        .i_raddr(wcnt[OFS_W-1:0]),
        .o_rdata(buf_rdata)
    );

    // loaded-byte mask, the new load wins over the clear
    always_ff @(posedge i_clock)
    begin
        if (i_reset || !vpp_s)
        begin
            loaded <= '0;
        end
        else
        begin
            loaded <= ((cycle_done && !erase_mode) ? '0 : loaded) |
                      (buf_we ? (32'h1 << offset) : '0);
        end
    end

    // polling reference is the last byte loaded
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            poll_ref <= ERASED_BYTE;
        end
        else if (buf_we)
        begin
            poll_ref <= bus_s;
        end
    end

    // ======================================================
    // programming engine
    logic [TMR_W-1:0] tmr;
    logic [PAGE_W-1:0] wpage;
    logic bo_hit;
    logic success;
    logic load_n;

    // cycles start when select rises after the command
    assign erase_go = sel_rise && session && state == ST_ARG1 &&
                      cmd == CMD_ERASE;
    assign write_go = sel_rise && session && state == ST_DATA &&
                      cmd == CMD_WRITE;
    assign cycle_start = (erase_go || write_go) && !busy;
    assign cycle_done = (pstate == P_WAIT) && (tmr == '0);

    // erase, page walk and timed wait
    always_ff @(posedge i_clock)
    begin
        if (i_reset || !vpp_s)
        begin
            pstate <= P_IDLE;
            tmr <= '0;
            wcnt <= '0;
            wpage <= '0;
            erase_mode <= 1'b0;
            o_flash_we <= 1'b0;
            o_flash_waddr <= '0;
            o_flash_wdata <= '0;
            o_flash_erase <= 1'b0;
            o_erase_user_row <= 1'b0;
            o_lock_clear <= 1'b0;
        end
        else
        begin
            o_flash_we <= 1'b0;
            o_flash_erase <= 1'b0;
            o_lock_clear <= 1'b0;
            unique case (pstate)
                P_IDLE:
                begin
                    if (cycle_start && erase_go)
                    begin
                        o_flash_erase <= !bo_s;
                        o_lock_clear <= !bo_s;
                        o_erase_user_row <= !i_user_row_fuse_n;
                        erase_mode <= 1'b1;
                        tmr <= TMR_W'(ERASE_CYCLES - 1);
                        pstate <= P_WAIT;
                    end
                    else if (cycle_start)
                    begin
                        erase_mode <= 1'b0;
                        wpage <= page_of(addr_hi, addr_lo);
                        wcnt <= '0;
                        pstate <= P_WALK;
                    end
                end
                P_WALK:
                begin
                    wcnt <= wcnt + 6'h01;
                    if (wcnt != '0 && loaded[walk_ofs] && !bo_s)
                    begin
                        o_flash_we <= 1'b1;
                        o_flash_waddr <= {wpage, walk_ofs};
                        o_flash_wdata <= buf_rdata;
                    end
                    if (wcnt == WALK_LAST)
                    begin
                        tmr <= TMR_W'(WRITE_CYCLES - 1);
                        pstate <= P_WAIT;
                    end
                end
                P_WAIT:
                begin
                    if (tmr == '0)
                    begin
                        pstate <= P_IDLE;
                    end
                    else
                    begin
                        tmr <= tmr - 17'h00001;
                    end
                end
            endcase
        end
    end

    // success and brownout tracking over a cycle
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            success <= SUCCESS_RST;
            bo_hit <= 1'b0;
        end
        else if (cycle_start)
        begin
            success <= 1'b0;
            bo_hit <= bo_s;
        end
        else if (busy)
        begin
            bo_hit <= bo_hit || bo_s;
            if (cycle_done)
            begin
                success <= !(bo_hit || bo_s);
            end
        end
    end

    // load flag: low on load command, high on next erase or write cycle start
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            load_n <= LOAD_RST;
        end
        else if (cycle_start)
        begin
            load_n <= 1'b1;
        end
        else if (take && state == ST_CODE && code_ok && bus_s == CMD_LOAD)
        begin
            load_n <= 1'b0;
        end
    end

    // ======================================================
    // read path and pins
    logic [BUS_W-1:0] state_byte;
    logic [BUS_W-1:0] poll_byte;

    // programming state byte
    always_comb
    begin
        state_byte = SB_FIXED;
        state_byte[SB_LOAD] = load_n;
        state_byte[SB_SUCCESS] = success;
        state_byte[SB_WRITE_INHIBIT_N] = !bo_s;
        state_byte[SB_BUSY_N] = !busy && !bo_s;
    end

    // polled value while a cycle runs
    assign poll_byte = erase_mode ? POLL_ERASE :
        {!poll_ref[BUS_W-1], poll_ref[BUS_W-2:0]};
    assign o_flash_raddr = {page_of(addr_hi, addr_lo), offset};

    // bus drive from fourth strobe fall until select rises
    always_ff @(posedge i_clock)
    begin
        if (i_reset || !vpp_s || sel_n_s)
        begin
            drive <= 1'b0;
        end
        else if (strobe_fall && state == ST_DATA &&
                 nstrobe == READ_STROBE &&
                 (cmd == CMD_STATUS || cmd == CMD_READ_CODE))
        begin
            drive <= 1'b1;
        end
    end

    // outgoing byte register
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            o_byte_bus <= '0;
        end
        else if (cmd == CMD_STATUS)
        begin
            o_byte_bus <= state_byte;
        end
        else
        begin
            o_byte_bus <= busy ? poll_byte : i_flash_rdata;
        end
    end

    assign o_byte_bus_oe = drive;
    assign o_ready_busy = !busy;
endmodule
`default_nettype wire

//--- shared/pfp_pkg.sv
// ==========================================================
// shared constants of the parallel flash program port
package pfp_pkg;
    // widths
    localparam int BUS_W = 8;
    localparam int OFS_W = 5;
    localparam int PAGE_W = 7;
    localparam int FADDR_W = 12;
    localparam int PAGE_BYTES = 32;
    localparam int NSTB_W = 3;
    localparam int WCNT_W = 6;
    localparam int TMR_W = 17;

    // synchroniser lanes
    localparam int SYNC_W = 12;
    localparam int SY_BUS_LSB = 0;
    localparam int SY_STROBE = 8;
    localparam int SY_SEL_N = 9;
    localparam int SY_VPP = 10;
    localparam int SY_BROWNOUT = 11;
    localparam logic [SYNC_W-1:0] SYNC_RST = 12'h200;

    // command bytes
    localparam logic [BUS_W-1:0] CMD_PREAMBLE = 8'haa;
    localparam logic [BUS_W-1:0] CMD_ENABLE = 8'hac;
    localparam logic [BUS_W-1:0] CMD_CONFIRM = 8'h53;
    localparam logic [BUS_W-1:0] CMD_ERASE = 8'h8a;
    localparam logic [BUS_W-1:0] CMD_LOAD = 8'h51;
    localparam logic [BUS_W-1:0] CMD_WRITE = 8'h50;
    localparam logic [BUS_W-1:0] CMD_STATUS = 8'h60;
    localparam logic [BUS_W-1:0] CMD_READ_CODE = 8'h30;

    // state byte layout
    localparam int SB_BUSY_N = 0;
    localparam int SB_WRITE_INHIBIT_N = 1;
    localparam int SB_SUCCESS = 2;
    localparam int SB_LOAD = 3;
    localparam logic [BUS_W-1:0] SB_FIXED = 8'h60;
    localparam logic SUCCESS_RST = 1'b1;
    localparam logic LOAD_RST = 1'b1;

    // polling
    localparam logic [BUS_W-1:0] POLL_ERASE = 8'h7f;
    localparam logic [BUS_W-1:0] ERASED_BYTE = 8'hff;

    // sequencing
    localparam logic [NSTB_W-1:0] READ_STROBE = 3'h4;
    localparam logic [NSTB_W-1:0] NSTB_MAX = 3'h7;
    localparam logic [WCNT_W-1:0] WALK_LAST = 6'h20;

    // timing
    localparam int CLOCK_MHZ = 25;
    localparam int ERASE_TIME_US = 4000;
    localparam int WRITE_TIME_US = 2000;
    localparam int ERASE_CYCLES_DEF = ERASE_TIME_US * CLOCK_MHZ;
    localparam int WRITE_CYCLES_DEF = WRITE_TIME_US * CLOCK_MHZ;

    typedef enum logic [5:0]
    {
        ST_PRE = 6'h01,
        ST_CODE = 6'h02,
        ST_ARG1 = 6'h04,
        ST_ARG2 = 6'h08,
        ST_DATA = 6'h10,
        ST_SKIP = 6'h20
    } pfp_cmd_state_e;

    typedef enum logic [2:0]
    {
        P_IDLE = 3'h1,
        P_WALK = 3'h2,
        P_WAIT = 3'h4
    } pfp_prog_state_e;
endpackage

//--- core/pfp_sync.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// two-stage synchroniser for all pin inputs
module pfp_sync
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // lanes
    input wire logic [pfp_pkg::SYNC_W-1:0] i_async,
    output logic [pfp_pkg::SYNC_W-1:0] o_sync
);
    import pfp_pkg::*;

    logic [SYNC_W-1:0] stage1;

    // first stage feeds only the second
    always_ff @(posedge i_clock)
    begin
        if (i_reset)
        begin
            stage1 <= SYNC_RST;
            o_sync <= SYNC_RST;
        end
        else
        begin
            stage1 <= i_async;
            o_sync <= stage1;
        end
    end
endmodule
`default_nettype wire

//--- core/pfp_page_buf.sv
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// 32-byte page buffer, registered read
module pfp_page_buf
(
    // clock
    input wire logic i_clock,
    // write port
    input wire logic i_we,
    input wire logic [pfp_pkg::OFS_W-1:0] i_waddr,
    input wire logic [pfp_pkg::BUS_W-1:0] i_wdata,
    // read port
    input wire logic [pfp_pkg::OFS_W-1:0] i_raddr,
    output logic [pfp_pkg::BUS_W-1:0] o_rdata
);
    import pfp_pkg::*;

    logic [BUS_W-1:0] mem [PAGE_BYTES];

    // store and read
    always_ff @(posedge i_clock)
    begin
        if (i_we)
        begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule
`default_nettype wire

//--- tb/pfp_top_assertions.sv
`timescale 1ns/1ns
`default_nettype none
// ==============================================
// port checks of the program port
module pfp_top_assertions
#(
    parameter int ERASE_CYCLES = 20,
    parameter int WRITE_CYCLES = 10
)
(
    // clock and reset
    input wire logic i_clock,
    input wire logic i_reset,
    // pins
    input wire logic i_iface_select_n,
    input wire logic i_byte_strobe,
    input wire logic i_brownout,
    input wire logic i_user_row_fuse_n,
    input wire logic o_byte_bus_oe,
    input wire logic o_ready_busy,
    // flash side
    input wire logic o_flash_we,
    input wire logic o_flash_erase,
    input wire logic o_lock_clear,
    input wire logic o_erase_user_row
);
    localparam int E_LO = ERASE_CYCLES - 2;
    localparam int E_HI = ERASE_CYCLES + 2;
    localparam int W_HI = WRITE_CYCLES + 40;

    default clocking cb @(posedge i_clock);
    endclocking
    default disable iff (i_reset);

    // busy pin held low through the start of a cycle
    sequence s_busy8;
        !o_ready_busy[*8];
    endsequence

    a_bus_release: assert property (
        i_iface_select_n[*4] |-> !o_byte_bus_oe)
        else $error("bus driven while deselected");
    a_oe_start: assert property ($rose(o_byte_bus_oe) |->
        !i_byte_strobe && !$past(i_iface_select_n, 3))
        else $error("bus drive began outside a strobe fall");
    a_erase_unlock: assert property (
        o_flash_erase |-> o_lock_clear)
        else $error("erase without lock clear");
    a_erase_once: assert property (
        o_flash_erase |=> !o_flash_erase)
        else $error("erase pulse longer than one clock");
    a_user_row: assert property (o_flash_erase |->
        o_erase_user_row == !i_user_row_fuse_n)
        else $error("user row erase disagrees with fuse");
    a_erase_busy: assert property (o_flash_erase |-> s_busy8)
        else $error("ready high during erase");
    a_erase_len: assert property (
        o_flash_erase |-> ##[E_LO:E_HI] o_ready_busy)
        else $error("erase length wrong");
    a_write_busy: assert property (
        o_flash_we |-> !o_ready_busy)
        else $error("flash write while ready");
    a_write_len: assert property (
        o_flash_we |-> ##[1:W_HI] o_ready_busy)
        else $error("write cycle too long");
    a_brown_nowr: assert property (i_brownout[*4] |->
        !o_flash_we && !o_flash_erase)
        else $error("flash altered during brownout");
endmodule

bind pfp_top pfp_top_assertions #(.ERASE_CYCLES(ERASE_CYCLES),
    .WRITE_CYCLES(WRITE_CYCLES)) u_chk (.i_clock(i_clock), .i_reset(i_reset),
    .i_iface_select_n(i_iface_select_n), .i_byte_strobe(i_byte_strobe),
    .i_brownout(i_brownout), .i_user_row_fuse_n(i_user_row_fuse_n),
    .o_byte_bus_oe(o_byte_bus_oe), .o_ready_busy(o_ready_busy),
    .o_flash_we(o_flash_we), .o_flash_erase(o_flash_erase),
    .o_lock_clear(o_lock_clear), .o_erase_user_row(o_erase_user_row));
`default_nettype wire

//--- tb/pfp_programmer.sv
`timescale 1ns/1ns
`default_nettype none
// ==============================================
// external programmer driving the byte bus
module pfp_programmer
(
    // clock
    input wire logic i_clock,
    // device side of the bus
    input wire logic [7:0] i_dev_bus,
    input wire logic i_dev_oe,
    // pins towards the device
    output logic [7:0] o_wire,
    output logic o_strobe,
    output logic o_select_n
);
    int hold = 4;
    logic drive = 1'b0;
    logic [7:0] data = 8'h00;

    // bus level; floats to inverse of last value
    assign o_wire = drive ? data : (i_dev_oe ? i_dev_bus : ~data);

    initial
    begin
        o_strobe = 1'b0;
        o_select_n = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge i_clock);
    endtask

    // one strobe pulse, data captured on rise
    task automatic pulse();
        o_strobe = 1'b1;
        tick(hold);
        o_strobe = 1'b0;
        tick(hold);
    endtask

    task automatic put(input logic [7:0] b);
        drive = 1'b1;
        data = b;
        tick(hold);
        pulse();
    endtask

    // whole command inside one select-low frame
    task automatic frame(input logic [7:0] b [$]);
        o_select_n = 1'b0;
        tick(4);
        foreach (b[i]) put(b[i]);
        o_select_n = 1'b1;
        drive = 1'b0;
        tick(8);
    endtask

    // read command, n bytes back from the fourth fall on
    task automatic rd(input logic [7:0] c, hi, lo, input int n,
        output logic [7:0] q [$]);
        q = {};
        o_select_n = 1'b0;
        tick(4);
        put(8'haa);
        put(c);
        put(hi);
        data = lo;
        tick(hold);
        o_strobe = 1'b1;
        tick(hold);
        drive = 1'b0;
        tick(2);
        o_strobe = 1'b0;
        tick(6);
        q.push_back(o_wire);
        repeat (n - 1)
        begin
            pulse();
            tick(2);
            q.push_back(o_wire);
        end
        o_select_n = 1'b1;
        tick(8);
    endtask
endmodule
`default_nettype wire

//--- tb/testbench.sv
`timescale 1ns/1ns
`default_nettype none
// ==============================================
// program port bench
module testbench;
    import pfp_pkg::*;
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic i_vpp_session = 1'b0;
    logic i_brownout = 1'b0;
    logic i_user_row_fuse_n = 1'b0;
    wire logic [7:0] bus_w, dev_q;
    wire logic strobe, sel_n, dev_oe, ready, we, erase, user_row, unlock;
    int n_unlock = 0;
    wire logic [11:0] waddr, raddr;
    wire logic [7:0] wdata;
    logic [7:0] mem [4096];
    int errors = 0;
    int n_compared = 0;

    // 25 MHz clock
    always #20 i_clock = ~i_clock;

    // flash array model
    always @(posedge i_clock)
    begin
        if (erase)
            foreach (mem[i]) mem[i] <= 8'hff;
        if (we)
            mem[waddr] <= wdata;
        if (unlock)
            n_unlock <= n_unlock + 1;
    end

    pfp_programmer prog (.i_clock(i_clock), .i_dev_bus(dev_q),
        .i_dev_oe(dev_oe), .o_wire(bus_w), .o_strobe(strobe),
        .o_select_n(sel_n));

    pfp_top #(.ERASE_CYCLES(400), .WRITE_CYCLES(400)) DUT (
        .i_clock(i_clock), .i_reset(i_reset), .i_byte_bus(bus_w),
        .o_byte_bus(dev_q), .o_byte_bus_oe(dev_oe), .i_byte_strobe(strobe),
        .i_iface_select_n(sel_n), .i_vpp_session(i_vpp_session),
        .o_ready_busy(ready), .i_brownout(i_brownout),
        .i_user_row_fuse_n(i_user_row_fuse_n),
        .o_flash_we(we), .o_flash_waddr(waddr),
        .o_flash_wdata(wdata), .o_flash_raddr(raddr),
        .i_flash_rdata(mem[raddr]), .o_flash_erase(erase),
        .o_erase_user_row(user_row), .o_lock_clear(unlock));

    task automatic stop_test();
        if (errors == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, exp);
        n_compared++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask

    // state byte read
    task automatic st(input logic [7:0] exp);
        logic [7:0] q [$];
        prog.rd(CMD_STATUS, 8'h00, 8'h00, 1, q);
        chk(q[0], exp);
    endtask

    task automatic wait_rdy();
        int k;
        k = 0;
        while (ready !== 1'b1 && k < 3000)
        begin
            @(negedge i_clock);
            k++;
        end
        if (ready !== 1'b1)
        begin
            errors++;
            $display("BAD %0t ready timeout", $time);
            stop_test();
        end
    endtask

    // main sequence
    initial
    begin
        logic [7:0] q [$];
        logic [7:0] exp [5];
        exp = '{8'h11, 8'h22, 8'h33, 8'h44, 8'h55};
        foreach (mem[i]) mem[i] = 8'h00;
        repeat (16) @(negedge i_clock);
        i_reset = 1'b0;
        prog.tick(8);
        i_vpp_session = 1'b1;
        prog.tick(8);
        prog.frame('{8'haa, 8'h8a});
        chk({7'h00, ready}, 8'h01);
        prog.frame('{8'haa, 8'hac, 8'h53});
        prog.rd(8'h30, 8'h00, 8'h00, 1, q);
        chk(q[0], 8'h00);
        st(8'h6f);
        prog.frame('{8'haa, 8'h77, 8'h00, 8'h1e, 8'h99});
        chk({7'h00, ready}, 8'h01);
        st(8'h6f);
        prog.frame('{8'haa, 8'h8a});
        chk({7'h00, ready}, 8'h00);
        prog.rd(8'h30, 8'h00, 8'h00, 1, q);
        chk(q[0], 8'h7f);
        st(8'h6a);
        wait_rdy();
        st(8'h6f);
        chk({7'h00, user_row}, 8'h01);
        chk(8'(n_unlock), 8'h01);
        prog.rd(8'h30, 8'h00, 8'h00, 1, q);
        chk(q[0], 8'hff);
        prog.frame('{8'haa, 8'h51, 8'h00, 8'h1e,
            8'h11, 8'h22, 8'h33});
        st(8'h67);
        prog.rd(8'h30, 8'h01, 8'h5e, 1, q);
        chk(q[0], 8'hff);
        prog.frame('{8'haa, 8'h50, 8'h01, 8'h41,
            8'h44, 8'h55});
        prog.rd(8'h30, 8'h00, 8'h00, 1, q);
        chk(q[0], 8'hd5);
        st(8'h6a);
        wait_rdy();
        prog.hold = 8;
        prog.rd(8'h30, 8'h01, 8'h5e, 5, q);
        foreach (exp[i]) chk(q[i], exp[i]);
        prog.hold = 4;
        prog.rd(8'h30, 8'h00, 8'h5e, 1, q);
        chk(q[0], 8'hff);
        st(8'h6f);
        i_brownout = 1'b1;
        prog.tick(4);
        st(8'h6c);
        i_brownout = 1'b0;
        i_user_row_fuse_n = 1'b1;
        prog.tick(4);
        prog.frame('{8'haa, 8'h8a});
        i_brownout = 1'b1;
        wait_rdy();
        st(8'h68);
        chk({7'h00, user_row}, 8'h00);
        chk(8'(n_unlock), 8'h02);
        i_brownout = 1'b0;
        prog.tick(4);
        st(8'h6b);
        i_vpp_session = 1'b0;
        prog.tick(8);
        i_vpp_session = 1'b1;
        prog.tick(8);
        prog.frame('{8'haa, 8'h8a});
        chk({7'h00, ready}, 8'h01);
        stop_test();
    end
endmodule
`default_nettype wire
